//--- hw/btx_cfg.svh
`ifndef BTX_CFG_SVH
`define BTX_CFG_SVH

// ----------------------------------------------------------------
// transfer limits
// ----------------------------------------------------------------
`define BTX_MAX_BYTES       16'h0080
`define BTX_BASE_MAX        8'h03
`define BTX_SLOT_MAX        8'h07
`define BTX_SLAVE_MAX_BCD   8'h90
`define BTX_NET_CNT_MAX_BCD 16'h0128
`define BTX_PORT_CODE       8'hF1
`define BTX_BCD_DIGIT_MAX   4'h9

// ----------------------------------------------------------------
// structure sizes
// ----------------------------------------------------------------
`define BTX_FIFO_WIDTH      8
`define BTX_FIFO_DEPTH      16
`define BTX_FAR_AW          8
`define BTX_FAR_BYTES       256

`endif

//--- hw/btx_pkg.sv
package btx_pkg;

  // ----------------------------------------------------------------
  // transfer operations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    module_read_op    = 2'b00,
    module_write_op   = 2'b01,
    network_read_op   = 2'b10,
    network_write_op  = 2'b11
  } btx_op_t;

  // ----------------------------------------------------------------
  // engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    dev_idle      = 3'b000,
    dev_wait_busy = 3'b001,
    dev_cmd       = 3'b010,
    dev_rd        = 3'b011,
    dev_wr_fetch  = 3'b100,
    dev_wr_send   = 3'b101,
    dev_done      = 3'b110
  } btx_dev_state_t;

  // ----------------------------------------------------------------
  // far end states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    far_idle = 2'b00,
    far_send = 2'b01,
    far_recv = 2'b10
  } btx_far_state_t;

endpackage

//--- hw/btx_link_if.sv
`timescale 1ns/10ps

interface btx_link_if;
  logic              cmd_valid;   // command offered by the engine
  logic              cmd_ready;   // far end takes the command
  btx_pkg::btx_op_t  cmd_op;      // operation
  logic [15:0]       cmd_sel;     // base/slot or slave/port selection
  logic [7:0]        cmd_count;   // byte count, binary
  logic [15:0]       cmd_addr;    // address inside the far end
  logic [15:0]       cmd_src;     // slave start location, network ops
  logic              h2m_valid;   // write byte offered
  logic              h2m_ready;   // write byte taken
  logic [7:0]        h2m_data;    // write byte
  logic              m2h_valid;   // read byte offered
  logic              m2h_ready;   // read byte taken
  logic [7:0]        m2h_data;    // read byte
  logic              busy;        // communication module busy

  modport dev (
    output cmd_valid, cmd_op, cmd_sel, cmd_count, cmd_addr, cmd_src,
    input  cmd_ready,
    output h2m_valid, h2m_data,
    input  h2m_ready,
    input  m2h_valid, m2h_data,
    output m2h_ready,
    input  busy
  );

  modport far (
    input  cmd_valid, cmd_op, cmd_sel, cmd_count, cmd_addr, cmd_src,
    output cmd_ready,
    input  h2m_valid, h2m_data,
    output h2m_ready,
    output m2h_valid, m2h_data,
    input  m2h_ready,
    output busy
  );
endinterface

//--- hw/btx_fifo.sv
`timescale 1ns/10ps
`include "btx_cfg.svh"

module btx_fifo #(
  parameter int WIDTH = `BTX_FIFO_WIDTH,
  parameter int DEPTH = `BTX_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // fill side
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_r [DEPTH];  // storage, no reset needed
  logic [AW:0]      wr_ptr_r;         // extra bit tells full from empty
  logic [AW:0]      rd_ptr_r;
  logic             full;
  logic             empty;

  assign empty     = (wr_ptr_r == rd_ptr_r);
  assign full      = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                     (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = store_r[rd_ptr_r[AW-1:0]];

  // ----------------------------------------------------------------
  // storage write
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (in_valid && !full) begin
      store_r[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  // ----------------------------------------------------------------
  // pointers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule

//--- hw/btx_far_end.sv
`timescale 1ns/10ps
`include "btx_cfg.svh"

module btx_far_end (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  // link
  btx_link_if.far                     lnk,
  // user memory port
  input  wire logic                   usr_we,
  input  wire logic [`BTX_FAR_AW-1:0] usr_addr,
  input  wire logic [7:0]             usr_wdata,
  output      logic [7:0]             usr_rdata,
  // status
  input  wire logic                   comm_module_busy_flag,
  output      btx_pkg::btx_op_t       last_op,
  output      logic [15:0]            last_sel,
  output      logic [15:0]            last_src,
  output      logic                   xfer_done
);
  logic [7:0]             mem_r [`BTX_FAR_BYTES];  // module data space
  btx_pkg::btx_far_state_t state_r;
  logic [`BTX_FAR_AW-1:0] ptr_r;       // next byte address
  logic [7:0]             left_r;      // bytes still to move
  logic [7:0]             tx_r;        // byte on offer
  logic                   cmd_hs;
  logic                   tx_hs;
  logic                   rx_hs;
  logic                   is_read;

  assign lnk.cmd_ready = (state_r == btx_pkg::far_idle);
  assign lnk.m2h_valid = (state_r == btx_pkg::far_send);
  assign lnk.m2h_data  = tx_r;
  assign lnk.h2m_ready = (state_r == btx_pkg::far_recv);
  assign lnk.busy      = comm_module_busy_flag;
  assign cmd_hs  = lnk.cmd_valid && lnk.cmd_ready;
  assign tx_hs   = lnk.m2h_valid && lnk.m2h_ready;
  assign rx_hs   = lnk.h2m_valid && lnk.h2m_ready;
  assign is_read = (lnk.cmd_op == btx_pkg::module_read_op) ||
                   (lnk.cmd_op == btx_pkg::network_read_op);

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r   <= btx_pkg::far_idle;
      ptr_r     <= '0;
      left_r    <= 8'h00;
      tx_r      <= 8'h00;
      xfer_done <= 1'b0;
    end else begin
      xfer_done <= 1'b0;
      case (state_r)
        btx_pkg::far_idle: begin
          if (cmd_hs) begin
            left_r <= lnk.cmd_count;
            if (lnk.cmd_count == 8'h00) begin
              xfer_done <= 1'b1;          // empty transfer ends at once
            end else if (is_read) begin
              tx_r    <= mem_r[lnk.cmd_addr[`BTX_FAR_AW-1:0]];
              ptr_r   <= lnk.cmd_addr[`BTX_FAR_AW-1:0] + 1'b1;
              state_r <= btx_pkg::far_send;
            end else begin
              ptr_r   <= lnk.cmd_addr[`BTX_FAR_AW-1:0];
              state_r <= btx_pkg::far_recv;
            end
          end
        end
        btx_pkg::far_send: begin
          if (tx_hs) begin
            left_r <= left_r - 8'h01;
            tx_r   <= mem_r[ptr_r];
            ptr_r  <= ptr_r + 1'b1;
            if (left_r == 8'h01) begin
              state_r   <= btx_pkg::far_idle;
              xfer_done <= 1'b1;
            end
          end
        end
        btx_pkg::far_recv: begin
          if (rx_hs) begin
            left_r <= left_r - 8'h01;
            ptr_r  <= ptr_r + 1'b1;
            if (left_r == 8'h01) begin
              state_r   <= btx_pkg::far_idle;
              xfer_done <= 1'b1;
            end
          end
        end
        default: begin
          state_r <= btx_pkg::far_idle;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // data space; the link wins a same-cycle collision with the user
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rx_hs) begin
      mem_r[ptr_r] <= lnk.h2m_data;
    end else if (usr_we) begin
      mem_r[usr_addr] <= usr_wdata;
    end
  end

  // ----------------------------------------------------------------
  // user read and last command record
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      usr_rdata <= 8'h00;
      last_op   <= btx_pkg::module_read_op;
      last_sel  <= 16'h0000;
      last_src  <= 16'h0000;
    end else begin
      usr_rdata <= mem_r[usr_addr];
      if (cmd_hs) begin
        last_op  <= lnk.cmd_op;
        last_sel <= lnk.cmd_sel;
        last_src <= lnk.cmd_src;
      end
    end
  end
endmodule

//--- hw/btx_engine.sv
`timescale 1ns/10ps
`include "btx_cfg.svh"

module btx_engine (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // instruction issue
  input  wire logic             op_valid,
  input  wire btx_pkg::btx_op_t op_code,
  input  wire logic [15:0]      acc,
  input  wire logic [15:0]      stack1,
  input  wire logic [15:0]      stack2,
  input  wire logic [15:0]      operand,
  input  wire logic             is_net_master,
  output      logic             op_ready,
  output      logic             op_done,
  output      logic             param_error_flag,
  output      logic             comm_module_busy_flag,
  // word memory
  output      logic             mem_req,
  output      logic             mem_we,
  output      logic [15:0]      mem_addr,
  output      logic [15:0]      mem_wdata,
  input  wire logic             mem_gnt,
  input  wire logic [15:0]      mem_rdata,
  // link
  btx_link_if.dev               lnk
);
  btx_pkg::btx_dev_state_t state_r;
  btx_pkg::btx_dev_state_t state_nxt;
  btx_pkg::btx_op_t op_r;          // captured operation
  logic [15:0]      sel_r;         // captured selection
  logic [15:0]      addr_r;        // captured far address
  logic [15:0]      src_r;         // captured slave start
  logic [7:0]       cnt_r;         // captured count, binary
  logic [7:0]       left_r;        // bytes still to move
  logic [15:0]      wptr_r;        // next word location
  logic             phase_r;       // high byte of the word is next
  logic [7:0]       hold_r;        // low byte while packing, high while sending
  logic [7:0]       tx_r;          // byte on offer to the far end
  logic             issue;
  logic             is_net;
  logic             is_rd;
  logic             mod_ok;
  logic             net_ok;
  logic             params_ok;
  logic [7:0]       cnt_bin;
  logic             fifo_valid;
  logic             fifo_ready;
  logic [7:0]       fifo_data;
  logic             pop;
  logic             tx_hs;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic bcd_ok(input logic [15:0] v);
    logic r;
    r = (v[3:0] <= `BTX_BCD_DIGIT_MAX) && (v[7:4] <= `BTX_BCD_DIGIT_MAX) &&
        (v[11:8] <= `BTX_BCD_DIGIT_MAX) && (v[15:12] <= `BTX_BCD_DIGIT_MAX);
    return r;
  endfunction

  function automatic logic [7:0] bcd_to_bin(input logic [11:0] v);
    logic [7:0] r;
    r = ({4'h0, v[11:8]} * 8'h64) + ({4'h0, v[7:4]} * 8'h0A) + {4'h0, v[3:0]};
    return r;
  endfunction

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  assign issue  = op_valid && (state_r == btx_pkg::dev_idle);
  assign is_net = op_code[1];
  assign is_rd  = (op_r == btx_pkg::module_read_op) ||
                  (op_r == btx_pkg::network_read_op);
  // base in the first byte, slot in the second; count 1..128
  assign mod_ok = (stack2[7:0] <= `BTX_BASE_MAX) &&
                  (stack2[15:8] <= `BTX_SLOT_MAX) &&
                  (stack1 != 16'h0000) && (stack1 <= `BTX_MAX_BYTES);
  // slave address in BCD, then port code or master slot; count even BCD
  assign net_ok = is_net_master &&
                  bcd_ok({8'h00, stack2[7:0]}) &&
                  (stack2[7:0] <= `BTX_SLAVE_MAX_BCD) &&
                  ((stack2[15:8] == `BTX_PORT_CODE) ||
                   (stack2[15:8] <= `BTX_SLOT_MAX)) &&
                  bcd_ok(stack1) && (stack1 <= `BTX_NET_CNT_MAX_BCD) &&
                  !stack1[0];
  assign params_ok = is_net ? net_ok : mod_ok;
  // an even BCD count's ones digit is even, so bit 0 tells parity
  assign cnt_bin   = is_net ? bcd_to_bin(stack1[11:0]) : stack1[7:0];

  // ----------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------
  assign op_ready              = (state_r == btx_pkg::dev_idle);
  assign op_done               = (state_r == btx_pkg::dev_done);
  assign comm_module_busy_flag = lnk.busy;
  assign lnk.cmd_valid = (state_r == btx_pkg::dev_cmd);
  assign lnk.cmd_op    = op_r;
  assign lnk.cmd_sel   = sel_r;
  assign lnk.cmd_count = cnt_r;
  assign lnk.cmd_addr  = addr_r;
  assign lnk.cmd_src   = src_r;
  assign lnk.h2m_valid = (state_r == btx_pkg::dev_wr_send);
  assign lnk.h2m_data  = tx_r;
  // the drain stalls while a word write waits, so the fifo can fill
  assign fifo_ready = (state_r == btx_pkg::dev_rd) && !mem_req;
  assign pop        = fifo_valid && fifo_ready;
  assign tx_hs      = lnk.h2m_valid && lnk.h2m_ready;

  btx_fifo #(
    .WIDTH (`BTX_FIFO_WIDTH),
    .DEPTH (`BTX_FIFO_DEPTH)
  ) u_rx_fifo (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .in_valid  (lnk.m2h_valid),
    .in_ready  (lnk.m2h_ready),
    .in_data   (lnk.m2h_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      btx_pkg::dev_idle: begin
        if (issue && !params_ok) begin
          state_nxt = btx_pkg::dev_done;       // refused, nothing moves
        end else if (issue) begin
          state_nxt = is_net ? btx_pkg::dev_wait_busy : btx_pkg::dev_cmd;
        end
      end
      btx_pkg::dev_wait_busy: begin
        if (!lnk.busy) begin
          state_nxt = btx_pkg::dev_cmd;
        end
      end
      btx_pkg::dev_cmd: begin
        if (lnk.cmd_ready) begin
          if (cnt_r == 8'h00) begin
            state_nxt = btx_pkg::dev_done;
          end else begin
            state_nxt = is_rd ? btx_pkg::dev_rd : btx_pkg::dev_wr_fetch;
          end
        end
      end
      btx_pkg::dev_rd: begin
        if ((left_r == 8'h00) && !mem_req) begin
          state_nxt = btx_pkg::dev_done;
        end
      end
      btx_pkg::dev_wr_fetch: begin
        if (mem_req && mem_gnt) begin
          state_nxt = btx_pkg::dev_wr_send;
        end
      end
      btx_pkg::dev_wr_send: begin
        if (tx_hs && (left_r == 8'h01)) begin
          state_nxt = btx_pkg::dev_done;
        end else if (tx_hs && phase_r) begin
          state_nxt = btx_pkg::dev_wr_fetch;
        end
      end
      btx_pkg::dev_done: begin
        state_nxt = btx_pkg::dev_idle;
      end
      default: begin
        state_nxt = btx_pkg::dev_idle;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= btx_pkg::dev_idle;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // parameter capture and error flag, only at issue
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      op_r             <= btx_pkg::module_read_op;
      sel_r            <= 16'h0000;
      addr_r           <= 16'h0000;
      src_r            <= 16'h0000;
      cnt_r            <= 8'h00;
      param_error_flag <= 1'b0;
    end else if (issue) begin
      param_error_flag <= !params_ok;
      if (params_ok) begin
        op_r   <= op_code;
        sel_r  <= stack2;
        addr_r <= acc;
        src_r  <= is_net ? operand : 16'h0000;
        cnt_r  <= cnt_bin;
      end
    end
  end

  // ----------------------------------------------------------------
  // byte counting and packing
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      left_r  <= 8'h00;
      phase_r <= 1'b0;
      hold_r  <= 8'h00;
      tx_r    <= 8'h00;
    end else if (issue) begin
      left_r  <= cnt_bin;
      phase_r <= 1'b0;
    end else if (pop) begin
      left_r  <= left_r - 8'h01;
      phase_r <= !phase_r;
      hold_r  <= fifo_data;
    end else if ((state_r == btx_pkg::dev_wr_fetch) && mem_req && mem_gnt) begin
      tx_r    <= mem_rdata[7:0];
      hold_r  <= mem_rdata[15:8];
      phase_r <= 1'b0;
    end else if (tx_hs) begin
      left_r  <= left_r - 8'h01;
      tx_r    <= hold_r;
      phase_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // word memory requests; a request holds until granted
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= 16'h0000;
      mem_wdata <= 16'h0000;
      wptr_r    <= 16'h0000;
    end else if (issue) begin
      wptr_r    <= operand;
    end else if (mem_req && mem_gnt) begin
      mem_req   <= 1'b0;
      wptr_r    <= wptr_r + 16'h0001;
    end else if ((state_r == btx_pkg::dev_wr_fetch) && !mem_req) begin
      mem_req   <= 1'b1;
      mem_we    <= 1'b0;
      mem_addr  <= wptr_r;
    end else if (pop && (phase_r || (left_r == 8'h01))) begin
      mem_req   <= 1'b1;
      mem_we    <= 1'b1;
      mem_addr  <= wptr_r;
      // odd last byte leaves the high byte zero
      mem_wdata <= phase_r ? {fifo_data, hold_r} : {8'h00, fifo_data};
    end
  end
endmodule

//--- verif/btx_link_monitor.sv
`timescale 1ns/10ps
module btx_link_monitor (
  // clock and reset
  input wire logic             sys_clk,
  input wire logic             nrst,
  // command channel
  input wire logic             cmd_valid,
  input wire logic             cmd_ready,
  input wire btx_pkg::btx_op_t cmd_op,
  input wire logic [15:0]      cmd_sel,
  input wire logic [7:0]       cmd_count,
  input wire logic [15:0]      cmd_addr,
  input wire logic [15:0]      cmd_src,
  // byte channels and busy
  input wire logic             h2m_valid,
  input wire logic             h2m_ready,
  input wire logic [7:0]       h2m_data,
  input wire logic             m2h_valid,
  input wire logic             m2h_ready,
  input wire logic [7:0]       m2h_data,
  input wire logic             busy
);
  // ----
  // one domain, so clock and reset are given once
  // ----
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // a command offered but not yet taken
  sequence cmd_wait;
    cmd_valid && !cmd_ready;
  endsequence
  a_cmd_hold: assert property (cmd_wait |=> cmd_valid
    && $stable({cmd_op, cmd_sel, cmd_count, cmd_addr, cmd_src})) else $error("command moved");
  a_cnt_max: assert property (cmd_valid |-> cmd_count <= 8'h80)
    else $error("count above limit");
  a_mod_cnt: assert property (cmd_valid && !cmd_op[1] |-> cmd_count != 8'h00)
    else $error("empty module transfer");
  a_net_even: assert property (cmd_valid && cmd_op[1] |-> !cmd_count[0])
    else $error("odd network count");
  a_mod_sel: assert property (cmd_valid && !cmd_op[1]
    |-> cmd_sel[7:0] <= 8'h03 && cmd_sel[15:8] <= 8'h07) else $error("bad base or slot");
  // start only counts when busy was already low
  a_net_idle: assert property ($rose(cmd_valid) && cmd_op[1] |-> !$past(busy))
    else $error("network start while busy");
  a_h2m_hold: assert property (h2m_valid && !h2m_ready |=> h2m_valid && $stable(h2m_data))
    else $error("write byte moved");
  a_m2h_hold: assert property (m2h_valid && !m2h_ready |=> m2h_valid && $stable(m2h_data))
    else $error("read byte moved");
endmodule

//--- verif/tb_plc_block_transfer_engine.sv
`timescale 1ns/10ps
module tb_plc_block_transfer_engine;
  // ----
  // bench signals
  // ----
  logic             sys_clk, nrst, op_valid, is_net_master, mem_gnt, stall, usr_we, cbusy;
  btx_pkg::btx_op_t op_code, last_op;
  logic [15:0]      acc, stack1, stack2, operand, mem_rdata, mem_addr, mem_wdata;
  logic             op_ready, op_done, perr, busy_o, mem_req, mem_we, xfer_done;
  logic [7:0]       usr_addr, usr_wdata, usr_rdata;
  logic [15:0]      last_sel, last_src;
  logic [15:0]      wmem [0:1023];   // cpu word memory
  int               miscompares, comparisons, xfers;
  btx_link_if lnk();
  btx_engine btx_engine_inst (.sys_clk, .nrst, .op_valid, .op_code, .acc, .stack1, .stack2,
    .operand, .is_net_master, .op_ready, .op_done, .param_error_flag(perr),
    .comm_module_busy_flag(busy_o), .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_gnt,
    .mem_rdata, .lnk(lnk.dev));
  btx_far_end btx_far_end_inst (.sys_clk, .nrst, .lnk(lnk.far), .usr_we, .usr_addr,
    .usr_wdata, .usr_rdata, .comm_module_busy_flag(cbusy), .last_op, .last_sel, .last_src,
    .xfer_done);
  btx_link_monitor btx_link_monitor_inst (.sys_clk, .nrst, .cmd_valid(lnk.cmd_valid),
    .cmd_ready(lnk.cmd_ready), .cmd_op(lnk.cmd_op), .cmd_sel(lnk.cmd_sel),
    .cmd_count(lnk.cmd_count), .cmd_addr(lnk.cmd_addr), .cmd_src(lnk.cmd_src),
    .h2m_valid(lnk.h2m_valid), .h2m_ready(lnk.h2m_ready), .h2m_data(lnk.h2m_data),
    .m2h_valid(lnk.m2h_valid), .m2h_ready(lnk.m2h_ready), .m2h_data(lnk.m2h_data),
    .busy(lnk.busy));
  initial begin
    sys_clk = 0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // word memory grants on the falling edge; stall holds the grant back to fill the fifo
  always @(negedge sys_clk) begin
    mem_gnt <= mem_req && !mem_gnt && !stall;
    mem_rdata <= wmem[mem_addr[9:0]];
  end
  always @(posedge sys_clk) if (mem_req && mem_gnt && mem_we) wmem[mem_addr[9:0]] <= mem_wdata;
  // far side end-of-transfer pulses, one per accepted command, empty ones included
  always @(negedge sys_clk) if (xfer_done === 1'b1) xfers++;
  // ----
  // tasks
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // issue one operation, wait for its done pulse and check the error flag
  task automatic run(input logic [1:0] op, input logic [15:0] a, s1, s2, opd, input logic e);
    int n;
    @(negedge sys_clk);
    op_valid = 1;
    op_code = btx_pkg::btx_op_t'(op);
    acc = a;
    stack1 = s1;
    stack2 = s2;
    operand = opd;
    @(negedge sys_clk);
    op_valid = 0;
    for (n = 0; n < 3000 && op_done !== 1'b1; n++) @(negedge sys_clk);
    chk({15'h0, op_done}, 16'h0001);
    chk({15'h0, perr}, {15'h0, e});
  endtask
  task automatic end_of_test();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (50000) @(posedge sys_clk);
    miscompares++;
    end_of_test();
  end
  // ----
  // main sequence
  // ----
  initial begin
    int i;
    int k;
    logic [33:0] bad [10];   // op, count, selection of refused issues
    bad = '{{2'd0, 16'h5, 16'h0004}, {2'd1, 16'h5, 16'h0800}, {2'd0, 16'h0, 16'h0001},
            {2'd1, 16'h81, 16'h0001}, {2'd2, 16'h10, 16'hF105}, {2'd3, 16'h10, 16'hF105},
            {2'd2, 16'h11, 16'hF105}, {2'd2, 16'h130, 16'hF105}, {2'd2, 16'h10, 16'hF191},
            {2'd2, 16'h10, 16'h0805}};
    {nrst, op_valid, is_net_master, stall, usr_we, cbusy, acc, stack1, stack2, operand} = '0;
    op_code = btx_pkg::module_read_op;
    {usr_addr, usr_wdata} = '0;
    for (i = 0; i < 8; i++) wmem[16'h180 + i] = {8'hC1 + 8'(2 * i), 8'hC0 + 8'(2 * i)};
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1;
    chk({15'h0, op_ready}, 16'h0001);
    // far data space holds address xor 5A
    for (i = 0; i < 256; i++) begin
      @(negedge sys_clk);
      usr_we = 1;
      usr_addr = 8'(i);
      usr_wdata = 8'(i) ^ 8'h5A;
    end
    @(negedge sys_clk);
    usr_we = 0;
    run(2'd0, 16'h0012, 16'h0005, 16'h0201, 16'h0100, 1'b0);
    chk(wmem[16'h100], 16'h4948);
    chk(wmem[16'h101], 16'h4F4E);
    chk(wmem[16'h102], 16'h004C);
    chk(last_sel, 16'h0201);
    // full 128 byte read with the memory stalled until the fifo refuses
    stall = 1;
    fork
      run(2'd0, 16'h0000, 16'h0080, 16'h0703, 16'h0200, 1'b0);
      begin
        for (k = 0; k < 400 && lnk.m2h_ready !== 1'b0; k++) @(negedge sys_clk);
        chk({15'h0, lnk.m2h_ready}, 16'h0000);
        stall = 0;
      end
    join
    chk(wmem[16'h200], 16'h5B5A);
    chk(wmem[16'h23F], 16'h2524);
    run(2'd1, 16'h0080, 16'h0006, 16'h0102, 16'h0180, 1'b0);
    for (k = 0; k < 6; k++) begin
      @(negedge sys_clk);
      usr_addr = 8'h80 + 8'(k);
      @(negedge sys_clk);
      chk({8'h0, usr_rdata}, {8'h0, 8'hC0 + 8'(k)});
    end
    // refused issues on every operation
    for (i = 0; i < 10; i++) begin
      if (i == 6) is_net_master = 1;
      run(bad[i][33:32], 16'h0000, bad[i][31:16], bad[i][15:0], 16'h0300, 1'b1);
    end
    // network read held off while the module is busy
    cbusy = 1;
    fork
      run(2'd2, 16'h0040, 16'h0016, 16'hF190, 16'h0400, 1'b0);
      begin
        repeat (10) @(negedge sys_clk);
        chk({15'h0, lnk.cmd_valid}, 16'h0000);
        chk({15'h0, busy_o}, 16'h0001);
        cbusy = 0;
      end
    join
    chk(last_sel, 16'hF190);
    chk(last_src, 16'h0400);
    chk({14'h0, last_op}, 16'h0002);
    for (k = 0; k < 8; k++) chk(wmem[16'h400 + k], {8'h41 + 8'(2 * k), 8'h40 + 8'(2 * k)}
      ^ 16'h5A5A);
    // network write takes the write path: four bytes from words 180 and 181
    run(2'd3, 16'h0060, 16'h0004, 16'hF105, 16'h0180, 1'b0);
    for (k = 0; k < 4; k++) begin
      @(negedge sys_clk);
      usr_addr = 8'h60 + 8'(k);
      @(negedge sys_clk);
      chk({8'h0, usr_rdata}, {8'h0, 8'hC0 + 8'(k)});
    end
    // five accepted transfers moved data; refused ones never reach the far end
    chk(16'(xfers), 16'h0005);
    end_of_test();
  end
endmodule
